//--- shared/mpcr_pkg.sv
package mpcr_pkg;
  // ==========================================================
  // register map: byte address = 4 * index
  // ==========================================================
  localparam int unsigned MPCR_ADDR_W = 8;
  localparam int unsigned MPCR_IDX_W = 6;
  localparam int unsigned MPCR_NREG = 8;
  localparam logic [5:0] MPCR_IDX_RAMP_LEVEL = 6'h15;
  localparam logic [5:0] MPCR_IDX_FIRST_TARI = 6'h16;
  localparam logic [5:0] MPCR_IDX_MAIN_REF_B = 6'h17;
  localparam logic [5:0] MPCR_IDX_MAIN_B_A = 6'h18;
  localparam logic [5:0] MPCR_IDX_MAIN_A_LOW = 6'h19;
  localparam logic [5:0] MPCR_IDX_AUX_B_HIGH = 6'h1A;
  localparam logic [5:0] MPCR_IDX_AUX_B_A = 6'h1B;
  localparam logic [5:0] MPCR_IDX_AUX_A_LOW = 6'h1C;
  localparam logic [5:0] MPCR_IDX_STATUS = 6'h1E;
  // entry 0 is index 15h, entry 7 is index 1Ch
  localparam logic [7:0][7:0] MPCR_RESET = {8'h18, 8'h61, 8'h04, 8'hFC, 8'h68, 8'h64, 8'h7E, 8'h00};
  localparam logic [7:0][7:0] MPCR_WMASK = {8'hFF, 8'hFF, 8'h0F, 8'hFF, 8'hFF, 8'h7F, 8'hFF, 8'hFF};
  // ==========================================================
  // field positions
  // ==========================================================
  localparam int unsigned MPCR_RAMP_MSB = 7;
  localparam int unsigned MPCR_RAMP_LSB = 6;
  localparam int unsigned MPCR_LIN_BIT = 5;
  localparam int unsigned MPCR_COARSE_MSB = 4;
  localparam int unsigned MPCR_COARSE_LSB = 3;
  localparam int unsigned MPCR_FINE_MSB = 2;
  localparam int unsigned MPCR_REF_MSB = 6;
  localparam int unsigned MPCR_REF_LSB = 4;
  localparam int unsigned MPCR_BHI_MSB = 3;
  localparam int unsigned MPCR_BLO_LSB = 2;
  localparam int unsigned MPCR_AHI_MSB = 1;
  localparam int unsigned MPCR_ST_REF_BAD = 0;
  localparam int unsigned MPCR_ST_COARSE_BAD = 1;
  localparam int unsigned MPCR_ST_TARI_RANGE = 2;
  // ==========================================================
  // codes and figures
  // ==========================================================
  localparam logic [8:0] MPCR_RAMP_T1_US = 9'd100;
  localparam logic [8:0] MPCR_RAMP_T2_US = 9'd200;
  localparam logic [8:0] MPCR_RAMP_T3_US = 9'd400;
  localparam logic [4:0] MPCR_COARSE_DB1 = 5'd8;
  localparam logic [4:0] MPCR_COARSE_DB2 = 5'd12;
  localparam logic [7:0] MPCR_TARI_MIN = 8'h5F;
  localparam logic [7:0] MPCR_TARI_MAX = 8'h9D;
  localparam logic [7:0] MPCR_STEP_NS_BASE = 8'd50;
  localparam logic [7:0] MPCR_REF_KHZ_100 = 8'd125;
  localparam logic [7:0] MPCR_REF_KHZ_101 = 8'd100;
  localparam logic [7:0] MPCR_REF_KHZ_110 = 8'd50;
  localparam logic [7:0] MPCR_REF_KHZ_111 = 8'd25;
  localparam logic [1:0] MPCR_RESP_OKAY = 2'b00;
  localparam logic [1:0] MPCR_RESP_DECERR = 2'b11;

  typedef enum logic [1:0] {
    MPCR_TARI_6U25 = 2'b00,
    MPCR_TARI_12U5 = 2'b01,
    MPCR_TARI_25U = 2'b10
  } mpcr_tari_t;
endpackage : mpcr_pkg

//--- shared/mpcr_reg_if.sv
interface mpcr_reg_if;
  import mpcr_pkg::*;
  logic wr_en;
  logic [MPCR_IDX_W-1:0] wr_idx;
  logic [7:0] wr_data;
  logic wr_hit;
  logic [MPCR_IDX_W-1:0] rd_idx;
  logic [7:0] rd_data;
  logic rd_hit;
  modport slave (output wr_en, wr_idx, wr_data, rd_idx, input wr_hit, rd_data, rd_hit);
  modport bank (input wr_en, wr_idx, wr_data, rd_idx, output wr_hit, rd_data, rd_hit);
endinterface : mpcr_reg_if

//--- rtl/mpcr_axil_slave.sv
module mpcr_axil_slave (
  // clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // write channels
  input wire logic [mpcr_pkg::MPCR_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // read channels
  input wire logic [mpcr_pkg::MPCR_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // register side
  mpcr_reg_if.slave rif
);
  import mpcr_pkg::*;
  logic aw_held_q, w_held_q, bvalid_q, rvalid_q, wlane_q;
  logic [MPCR_ADDR_W-1:0] awaddr_q;
  logic [7:0] wdata_q;
  logic [1:0] bresp_q, rresp_q;
  logic [31:0] rdata_q;

  // ==========================================================
  // write path: address and data accepted in either order
  // ==========================================================
  assign s_axi_awready = !aw_held_q && !bvalid_q;
  assign s_axi_wready = !w_held_q && !bvalid_q;
  wire aw_hs = s_axi_awvalid && s_axi_awready;
  wire w_hs = s_axi_wvalid && s_axi_wready;
  wire do_wr = (aw_held_q || aw_hs) && (w_held_q || w_hs);
  wire [MPCR_ADDR_W-1:0] wr_addr = aw_held_q ? awaddr_q : s_axi_awaddr;
  wire wr_lane = w_held_q ? wlane_q : s_axi_wstrb[0];
  wire wr_ok = rif.wr_hit && (wr_addr[1:0] == 2'h0);
  assign rif.wr_idx = wr_addr[MPCR_ADDR_W-1:2];
  assign rif.wr_data = w_held_q ? wdata_q : s_axi_wdata[7:0];
  // registers are 8 bits wide, so only byte lane 0 can change them
  assign rif.wr_en = do_wr && wr_lane && wr_ok;

  // ==========================================================
  // read path
  // ==========================================================
  assign s_axi_arready = !rvalid_q;
  wire ar_hs = s_axi_arvalid && s_axi_arready;
  wire rd_ok = rif.rd_hit && (s_axi_araddr[1:0] == 2'h0);
  assign rif.rd_idx = s_axi_araddr[MPCR_ADDR_W-1:2];

  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rresp = rresp_q;
  assign s_axi_rdata = rdata_q;

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      aw_held_q <= 1'b0;
      w_held_q <= 1'b0;
      awaddr_q <= '0;
      wdata_q <= 8'h00;
      wlane_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= MPCR_RESP_OKAY;
      rvalid_q <= 1'b0;
      rresp_q <= MPCR_RESP_OKAY;
      rdata_q <= 32'h0000_0000;
    end else begin
      aw_held_q <= !do_wr && (aw_held_q || aw_hs);
      w_held_q <= !do_wr && (w_held_q || w_hs);
      if (aw_hs) begin
        awaddr_q <= s_axi_awaddr;
      end
      if (w_hs) begin
        wdata_q <= s_axi_wdata[7:0];
        wlane_q <= s_axi_wstrb[0];
      end
      if (do_wr) begin
        bvalid_q <= 1'b1;
        bresp_q <= wr_ok ? MPCR_RESP_OKAY : MPCR_RESP_DECERR;
      end else if (s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
      if (ar_hs) begin
        rvalid_q <= 1'b1;
        rresp_q <= rd_ok ? MPCR_RESP_OKAY : MPCR_RESP_DECERR;
        rdata_q <= {24'h00_0000, rd_ok ? rif.rd_data : 8'h00};
      end else if (s_axi_rready) begin
        rvalid_q <= 1'b0;
      end
    end
  end
endmodule : mpcr_axil_slave

//--- rtl/mpcr_div_ratio.sv
module mpcr_div_ratio (
  // clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // divider settings
  input wire logic [9:0] b_value,
  input wire logic [9:0] a_value,
  input wire logic [7:0] ref_khz,
  // results
  output logic [16:0] ratio,
  output logic [24:0] freq_khz
);
  import mpcr_pkg::*;
  logic [16:0] ratio_q;
  logic [24:0] freq_q;
  // 32/33 dual-modulus prescaler: n = 32 b + 33 a, at most 66495
  wire [16:0] ratio_d = 17'({b_value, 5'b0_0000}) + 17'({a_value, 5'b0_0000}) + 17'(a_value);
  wire [24:0] freq_d = 25'(ref_khz) * 25'(ratio_d);

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      ratio_q <= 17'h0_0000;
      freq_q <= 25'h000_0000;
    end else begin
      ratio_q <= ratio_d;
      freq_q <= freq_d;
    end
  end
  assign ratio = ratio_q;
  assign freq_khz = freq_q;

  carrier_freq_a: assert property (@(posedge mclk) disable iff (!resetn)
    resetn |=> freq_khz == 25'($past(ref_khz)) * 25'(ratio))
    else $error("carrier frequency is not reference times ratio");
endmodule : mpcr_div_ratio

//--- rtl/mpcr_config_bank.sv
module mpcr_config_bank (
  // clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // axi4-lite write channels
  input wire logic [mpcr_pkg::MPCR_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read channels
  input wire logic [mpcr_pkg::MPCR_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // link timing in use
  input wire mpcr_pkg::mpcr_tari_t tari_sel,
  // modulator controls
  output logic tx_ramp_tari_based,
  output logic [8:0] tx_ramp_time_us,
  output logic tx_linear_transient,
  output logic [4:0] tx_coarse_atten_db,
  output logic [2:0] tx_fine_atten_db,
  output logic [7:0] first_symbol_high_len,
  output logic [15:0] first_symbol_high_ns,
  // synthesizer controls
  output logic [2:0] synth_ref_divider_sel,
  output logic [7:0] synth_ref_khz,
  output logic [9:0] main_div_b_value,
  output logic [9:0] main_div_a_value,
  output logic [16:0] main_div_ratio,
  output logic [24:0] main_carrier_khz,
  output logic [9:0] aux_div_b_value,
  output logic [9:0] aux_div_a_value,
  output logic [16:0] aux_div_ratio,
  output logic [24:0] aux_carrier_khz
);
  import mpcr_pkg::*;

  mpcr_reg_if rif ();
  logic [7:0] regs_q [MPCR_NREG];

  // ==========================================================
  // bus slave
  // ==========================================================
  mpcr_axil_slave u_slave (
    .mclk(mclk),
    .resetn(resetn),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .rif(rif)
  );

  // ==========================================================
  // register array and decode
  // ==========================================================
  wire [MPCR_IDX_W-1:0] wr_rel = rif.wr_idx - MPCR_IDX_RAMP_LEVEL;
  wire [MPCR_IDX_W-1:0] rd_rel = rif.rd_idx - MPCR_IDX_RAMP_LEVEL;
  wire wr_in_bank = (rif.wr_idx >= MPCR_IDX_RAMP_LEVEL) && (rif.wr_idx <= MPCR_IDX_AUX_A_LOW);
  wire rd_in_bank = (rif.rd_idx >= MPCR_IDX_RAMP_LEVEL) && (rif.rd_idx <= MPCR_IDX_AUX_A_LOW);
  // the status word takes writes without effect, so it answers okay
  assign rif.wr_hit = wr_in_bank || (rif.wr_idx == MPCR_IDX_STATUS);
  assign rif.rd_hit = rd_in_bank || (rif.rd_idx == MPCR_IDX_STATUS);

  genvar gi;
  generate
    for (gi = 0; gi < MPCR_NREG; gi++) begin : g_reg
      // unused bits are masked on write and so always read back as zero
      always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
          regs_q[gi] <= MPCR_RESET[gi];
        end else if (rif.wr_en && wr_in_bank && (wr_rel == MPCR_IDX_W'(gi))) begin
          regs_q[gi] <= rif.wr_data & MPCR_WMASK[gi];
        end
      end
    end
  endgenerate

  // named views of the stored bytes
  wire [7:0] ramp_level_r = regs_q[0];
  wire [7:0] first_tari_r = regs_q[1];
  wire [7:0] main_ref_b_r = regs_q[2];
  wire [7:0] main_b_a_r = regs_q[3];
  wire [7:0] main_a_low_r = regs_q[4];
  wire [7:0] aux_b_high_r = regs_q[5];
  wire [7:0] aux_b_a_r = regs_q[6];
  wire [7:0] aux_a_low_r = regs_q[7];

  // ==========================================================
  // modulator decode
  // ==========================================================
  wire [1:0] ramp_code = ramp_level_r[MPCR_RAMP_MSB:MPCR_RAMP_LSB];
  wire [1:0] coarse_code = ramp_level_r[MPCR_COARSE_MSB:MPCR_COARSE_LSB];
  wire [8:0] ramp_us_d = (ramp_code == 2'b01) ? MPCR_RAMP_T1_US :
                         (ramp_code == 2'b10) ? MPCR_RAMP_T2_US :
                         (ramp_code == 2'b11) ? MPCR_RAMP_T3_US : 9'h000;
  // a forbidden coarse code falls back to the deepest documented level rather than full power
  wire [4:0] coarse_db_d = (coarse_code == 2'b00) ? 5'h00 :
                           (coarse_code == 2'b01) ? MPCR_COARSE_DB1 : MPCR_COARSE_DB2;
  // step is 50 ns doubled for each doubling of Tari; an unlisted Tari code uses the longest step
  wire [1:0] step_shift = (tari_sel == MPCR_TARI_6U25) ? 2'd0 :
                          (tari_sel == MPCR_TARI_12U5) ? 2'd1 : 2'd2;
  wire [15:0] step_ns = 16'(MPCR_STEP_NS_BASE) << step_shift;
  wire [15:0] high_ns_d = 16'(16'(first_tari_r) * step_ns);
  wire tari_out_of_range = (first_tari_r < MPCR_TARI_MIN) || (first_tari_r > MPCR_TARI_MAX);

  // ==========================================================
  // synthesizer decode
  // ==========================================================
  wire [2:0] ref_code = main_ref_b_r[MPCR_REF_MSB:MPCR_REF_LSB];
  // codes below 100 are forbidden: the reference is shown as 0 kHz and flagged
  wire [7:0] ref_khz_d = (ref_code == 3'b100) ? MPCR_REF_KHZ_100 :
                         (ref_code == 3'b101) ? MPCR_REF_KHZ_101 :
                         (ref_code == 3'b110) ? MPCR_REF_KHZ_110 :
                         (ref_code == 3'b111) ? MPCR_REF_KHZ_111 : 8'h00;
  wire [9:0] main_b_d = {main_ref_b_r[MPCR_BHI_MSB:0], main_b_a_r[7:MPCR_BLO_LSB]};
  wire [9:0] main_a_d = {main_b_a_r[MPCR_AHI_MSB:0], main_a_low_r};
  wire [9:0] aux_b_d = {aux_b_high_r[MPCR_BHI_MSB:0], aux_b_a_r[7:MPCR_BLO_LSB]};
  wire [9:0] aux_a_d = {aux_b_a_r[MPCR_AHI_MSB:0], aux_a_low_r};

  mpcr_div_ratio u_main_div (
    .mclk(mclk),
    .resetn(resetn),
    .b_value(main_b_d),
    .a_value(main_a_d),
    .ref_khz(ref_khz_d),
    .ratio(main_div_ratio),
    .freq_khz(main_carrier_khz)
  );

  // the auxiliary loop shares the main reference divider
  mpcr_div_ratio u_aux_div (
    .mclk(mclk),
    .resetn(resetn),
    .b_value(aux_b_d),
    .a_value(aux_a_d),
    .ref_khz(ref_khz_d),
    .ratio(aux_div_ratio),
    .freq_khz(aux_carrier_khz)
  );

  // ==========================================================
  // status word and read mux
  // ==========================================================
  wire [7:0] status_w = {5'h00, tari_out_of_range, coarse_code == 2'b11, ref_khz_d == 8'h00};
  assign rif.rd_data = (rif.rd_idx == MPCR_IDX_STATUS) ? status_w :
                       rd_in_bank ? regs_q[rd_rel[2:0]] : 8'h00;

  // ==========================================================
  // output registers
  // ==========================================================
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      tx_ramp_tari_based <= 1'b1;
      tx_ramp_time_us <= 9'h000;
      tx_linear_transient <= 1'b0;
      tx_coarse_atten_db <= 5'h00;
      tx_fine_atten_db <= 3'h0;
      first_symbol_high_len <= 8'h00;
      first_symbol_high_ns <= 16'h0000;
      synth_ref_divider_sel <= 3'h0;
      synth_ref_khz <= 8'h00;
      main_div_b_value <= 10'h000;
      main_div_a_value <= 10'h000;
      aux_div_b_value <= 10'h000;
      aux_div_a_value <= 10'h000;
    end else begin
      tx_ramp_tari_based <= (ramp_code == 2'b00);
      tx_ramp_time_us <= ramp_us_d;
      tx_linear_transient <= ramp_level_r[MPCR_LIN_BIT];
      tx_coarse_atten_db <= coarse_db_d;
      tx_fine_atten_db <= ramp_level_r[MPCR_FINE_MSB:0];
      first_symbol_high_len <= first_tari_r;
      first_symbol_high_ns <= high_ns_d;
      synth_ref_divider_sel <= ref_code;
      synth_ref_khz <= ref_khz_d;
      main_div_b_value <= main_b_d;
      main_div_a_value <= main_a_d;
      aux_div_b_value <= aux_b_d;
      aux_div_a_value <= aux_a_d;
    end
  end

  // ==========================================================
  // checks
  // ==========================================================
  ramp_time_code_a: assert property (@(posedge mclk) disable iff (!resetn)
    (resetn && ramp_code == 2'b10) |=> (tx_ramp_time_us == 9'd200) && !tx_ramp_tari_based)
    else $error("ramp code 10 did not give 200 us");

  transient_shape_a: assert property (@(posedge mclk) disable iff (!resetn)
    resetn |=> tx_linear_transient == $past(ramp_level_r[5]))
    else $error("transient shape does not follow its bit");

  coarse_level_a: assert property (@(posedge mclk) disable iff (!resetn)
    (resetn && coarse_code == 2'b01) |=> (tx_coarse_atten_db == 5'd8))
    else $error("coarse code 01 did not give 8 dB");

  fine_level_a: assert property (@(posedge mclk) disable iff (!resetn)
    (resetn && ramp_level_r[2:0] == 3'b111) |=> (tx_fine_atten_db == 3'd7))
    else $error("fine code 111 did not give 7 dB");

  tari_range_flag_a: assert property (@(posedge mclk) disable iff (!resetn)
    (first_tari_r == 8'h9E) |-> status_w[2])
    else $error("first tari 9Eh not flagged out of range");

  first_tari_step_a: assert property (@(posedge mclk) disable iff (!resetn)
    (resetn && tari_sel == MPCR_TARI_12U5) |=> (first_symbol_high_ns == 16'($past(first_tari_r)) * 16'd100))
    else $error("first tari step at 12.5 us is not 100 ns");

  ref_select_a: assert property (@(posedge mclk) disable iff (!resetn)
    (resetn && ref_code == 3'b110) |=> (synth_ref_khz == 8'd50))
    else $error("reference code 110 did not give 50 kHz");

  main_ratio_a: assert property (@(posedge mclk) disable iff (!resetn)
    resetn |=> main_div_ratio == 17'($past(main_b_d)) * 17'd32 + 17'($past(main_a_d)) * 17'd33)
    else $error("main ratio is not 32 b plus 33 a");

  main_packing_a: assert property (@(posedge mclk) disable iff (!resetn)
    (rif.wr_en && rif.wr_idx == 6'h18) |=> ##1 (main_div_a_value[9:8] == $past(rif.wr_data[1:0], 2)))
    else $error("write to 18h did not land in main a 9:8");

  aux_packing_a: assert property (@(posedge mclk) disable iff (!resetn)
    (rif.wr_en && rif.wr_idx == 6'h1A) |=> (aux_b_high_r == {4'h0, $past(rif.wr_data[3:0])}))
    else $error("write to 1Ah stored unused bits or lost b 9:6");

  aux_ratio_a: assert property (@(posedge mclk) disable iff (!resetn)
    resetn |=> aux_div_ratio == 17'($past(aux_b_d)) * 17'd32 + 17'($past(aux_a_d)) * 17'd33)
    else $error("aux ratio is not 32 b plus 33 a");

  ramp_tari_based_a: assert property (@(posedge mclk) disable iff (!resetn)
    (resetn && ramp_code == 2'b00) |=> tx_ramp_tari_based && (tx_ramp_time_us == 9'd0))
    else $error("ramp code 00 is not tari based");

  coarse_deep_a: assert property (@(posedge mclk) disable iff (!resetn)
    (resetn && coarse_code == 2'b10) |=> (tx_coarse_atten_db == 5'd12))
    else $error("coarse code 10 did not give 12 dB");

  fine_follows_a: assert property (@(posedge mclk) disable iff (!resetn)
    resetn |=> tx_fine_atten_db == $past(ramp_level_r[2:0]))
    else $error("fine level does not follow its field");

  first_tari_len_a: assert property (@(posedge mclk) disable iff (!resetn)
    resetn |=> first_symbol_high_len == $past(first_tari_r))
    else $error("first tari length does not follow its register");

  slow_tari_step_a: assert property (@(posedge mclk) disable iff (!resetn)
    (resetn && tari_sel == MPCR_TARI_25U) |=> (first_symbol_high_ns == 16'($past(first_tari_r)) * 16'd200))
    else $error("first tari step at 25 us is not 200 ns");

  ref_fast_a: assert property (@(posedge mclk) disable iff (!resetn)
    (resetn && ref_code == 3'b100) |=> (synth_ref_khz == 8'd125))
    else $error("reference code 100 did not give 125 kHz");

  main_b_high_a: assert property (@(posedge mclk) disable iff (!resetn)
    resetn |=> main_div_b_value[9:6] == $past(main_ref_b_r[3:0]))
    else $error("main b 9:6 does not come from 17h");

  aux_b_low_a: assert property (@(posedge mclk) disable iff (!resetn)
    resetn |=> aux_div_b_value[5:0] == $past(aux_b_a_r[7:2]))
    else $error("aux b 5:0 does not come from 1Bh");

  aux_a_low_a: assert property (@(posedge mclk) disable iff (!resetn)
    resetn |=> aux_div_a_value[7:0] == $past(aux_a_low_r))
    else $error("aux a 7:0 does not come from 1Ch");
endmodule : mpcr_config_bank

//--- verification/tb.sv
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import mpcr_pkg::*;
  // ==========================================================
  // design hookup
  // ==========================================================
  logic mclk = 1'b0, resetn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'h0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  mpcr_tari_t tari_sel = MPCR_TARI_6U25;
  logic tx_ramp_tari_based, tx_linear_transient;
  logic [8:0] tx_ramp_time_us;
  logic [4:0] tx_coarse_atten_db;
  logic [2:0] tx_fine_atten_db, synth_ref_divider_sel;
  logic [7:0] first_symbol_high_len, synth_ref_khz;
  logic [15:0] first_symbol_high_ns;
  logic [9:0] main_div_b_value, main_div_a_value, aux_div_b_value, aux_div_a_value;
  logic [16:0] main_div_ratio, aux_div_ratio;
  logic [24:0] main_carrier_khz, aux_carrier_khz;
  int error_cnt = 0;
  int checks = 0;
  always #5 mclk = ~mclk;
  mpcr_config_bank mpcr_config_bank_i (.mclk(mclk), .resetn(resetn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .tari_sel(tari_sel), .tx_ramp_tari_based(tx_ramp_tari_based), .tx_ramp_time_us(tx_ramp_time_us),
    .tx_linear_transient(tx_linear_transient), .tx_coarse_atten_db(tx_coarse_atten_db),
    .tx_fine_atten_db(tx_fine_atten_db), .first_symbol_high_len(first_symbol_high_len),
    .first_symbol_high_ns(first_symbol_high_ns), .synth_ref_divider_sel(synth_ref_divider_sel),
    .synth_ref_khz(synth_ref_khz), .main_div_b_value(main_div_b_value), .main_div_a_value(main_div_a_value),
    .main_div_ratio(main_div_ratio), .main_carrier_khz(main_carrier_khz), .aux_div_b_value(aux_div_b_value),
    .aux_div_a_value(aux_div_a_value), .aux_div_ratio(aux_div_ratio), .aux_carrier_khz(aux_carrier_khz));
  // ==========================================================
  // bus tasks
  // ==========================================================
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      error_cnt++;
      $display("mismatch %s expected %0h seen %0h", nm, e, g);
    end
  endtask : chk
  // every task ends one edge after its last release, so no strobe is set twice in one step
  // no local limit on the wait: a missing answer is caught by the watchdog
  task automatic axi_write(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= {24'h0, d};
    s_axi_wstrb <= 4'hF;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge mclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    chk("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
    s_axi_bready <= 1'b0;
    @(posedge mclk);
  endtask : axi_write
  task automatic axi_read(input logic [7:0] a, input logic [7:0] ed, input logic [1:0] er);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge mclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    chk("rresp", {30'h0, er}, {30'h0, s_axi_rresp});
    if (er === MPCR_RESP_OKAY) chk("rdata", {24'h0, ed}, s_axi_rdata);
    s_axi_rready <= 1'b0;
    @(posedge mclk);
  endtask : axi_read
  // decoded and derived outputs trail the register write by one edge
  task automatic settle;
    repeat (3) @(posedge mclk);
  endtask : settle
  task automatic final_report;
    if (error_cnt == 0 && checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : final_report
  // ==========================================================
  // tests
  // ==========================================================
  logic [7:0] rst_val [8] = '{8'h00, 8'h7E, 8'h64, 8'h68, 8'hFC, 8'h04, 8'h61, 8'h18};
  int ramp_us [4] = '{0, 100, 200, 400};
  int coarse_db [3] = '{0, 8, 12};
  int ref_khz [4] = '{125, 100, 50, 25};
  logic [7:0] tv [2] = '{8'h5F, 8'h9D};
  initial begin
    repeat (8) @(posedge mclk);
    resetn <= 1'b1;
    @(posedge mclk);
    for (int i = 0; i < 8; i++) axi_read(8'h54 + 8'(4 * i), rst_val[i], MPCR_RESP_OKAY);
    settle();
    chk("ramp_tari", 32'h1, {31'h0, tx_ramp_tari_based});
    chk("main_b", 32'h11A, {22'h0, main_div_b_value});
    chk("main_ratio", 32 * 32'h11A + 33 * 32'hFC, {15'h0, main_div_ratio});
    for (int k = 0; k < 4; k++) begin
      axi_write(8'h54, {2'(k), 1'(k), 2'(k < 3 ? k : 2), 3'(2 * k + 1)}, MPCR_RESP_OKAY);
      settle();
      chk("ramp_us", ramp_us[k], {23'h0, tx_ramp_time_us});
      chk("ramp_tari", (k == 0), {31'h0, tx_ramp_tari_based});
      chk("linear", k % 2, {31'h0, tx_linear_transient});
      chk("coarse", coarse_db[k < 3 ? k : 2], {27'h0, tx_coarse_atten_db});
      chk("fine", 2 * k + 1, {29'h0, tx_fine_atten_db});
    end
    for (int v = 0; v < 2; v++) begin
      axi_write(8'h58, tv[v], MPCR_RESP_OKAY);
      for (int t = 0; t < 3; t++) begin
        tari_sel <= mpcr_tari_t'(t);
        settle();
        chk("tari_ns", tv[v] * (50 << t), {16'h0, first_symbol_high_ns});
      end
      chk("tari_len", {24'h0, tv[v]}, {24'h0, first_symbol_high_len});
    end
    for (int c = 4; c < 8; c++) begin
      axi_write(8'h5C, {1'b0, 3'(c), 4'h6}, MPCR_RESP_OKAY);
      settle();
      chk("ref_khz", ref_khz[c - 4], {24'h0, synth_ref_khz});
      chk("ref_sel", c, {29'h0, synth_ref_divider_sel});
    end
    axi_write(8'h5C, 8'h66, MPCR_RESP_OKAY);
    axi_write(8'h60, 8'h50, MPCR_RESP_OKAY);
    axi_write(8'h64, 8'h86, MPCR_RESP_OKAY);
    axi_write(8'h68, 8'hF6, MPCR_RESP_OKAY);
    axi_write(8'h6C, 8'h50, MPCR_RESP_OKAY);
    axi_write(8'h70, 8'h86, MPCR_RESP_OKAY);
    axi_read(8'h68, 8'h06, MPCR_RESP_OKAY);
    settle();
    chk("main_b", 32'h194, {22'h0, main_div_b_value});
    chk("main_a", 32'h086, {22'h0, main_div_a_value});
    chk("main_ratio", 17350, {15'h0, main_div_ratio});
    chk("main_khz", 867500, {7'h0, main_carrier_khz});
    chk("aux_b", 32'h194, {22'h0, aux_div_b_value});
    chk("aux_a", 32'h086, {22'h0, aux_div_a_value});
    chk("aux_ratio", 17350, {15'h0, aux_div_ratio});
    chk("aux_khz", 867500, {7'h0, aux_carrier_khz});
    axi_read(8'h00, 8'h00, MPCR_RESP_DECERR);
    axi_read(8'h55, 8'h00, MPCR_RESP_DECERR);
    axi_write(8'h04, 8'hA5, MPCR_RESP_DECERR);
    axi_read(8'h64, 8'h86, MPCR_RESP_OKAY);
    axi_write(8'h58, 8'h9E, MPCR_RESP_OKAY);
    axi_write(8'h78, 8'hFF, MPCR_RESP_OKAY);
    axi_read(8'h78, 8'h04, MPCR_RESP_OKAY);
    final_report();
  end
  initial begin
    repeat (20000) @(posedge mclk);
    error_cnt++;
    final_report();
  end
endmodule : tb
